// File: design/pctach_consts.vh
// Constants used by the pulse counter and tachometer top-level design file
`ifndef PCTACH_CONSTS_VH
`define PCTACH_CONSTS_VH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define PCTACH_CLK_KHZ 20000
`define PCTACH_GATE_TIME_MS 1000
`define PCTACH_GATE_CYCLES (`PCTACH_GATE_TIME_MS * `PCTACH_CLK_KHZ)

// ----------------------------------------------------------------
// Encodings, setting ranges and reset values
// ----------------------------------------------------------------
`define PCTACH_MODE_ROTATION 2'h0
`define PCTACH_MODE_COUNT_UP 2'h1
`define PCTACH_MODE_COUNT_DOWN 2'h2
`define PCTACH_SRC_LOGIC 2'h0
`define PCTACH_SRC_SINKING 2'h1
`define PCTACH_SRC_SOURCING 2'h2
`define PCTACH_SRC_MAX 24'h00_0002
`define PCTACH_LIM_OFF 2'h0
`define PCTACH_LIM_ERROR 2'h1
`define PCTACH_LIM_CLAMP 2'h2
`define PCTACH_LIM_MAX 24'h00_0002
`define PCTACH_DP_MAX 24'h00_0003
`define PCTACH_EDGE_MAX 24'h00_0001
`define PCTACH_PRESC_MAX 24'h00_FFFF
`define PCTACH_FS_MAX 24'h00_270F
`define PCTACH_SET_MIN1 24'h00_0001
`define PCTACH_SET_MIN0 24'h00_0000
`define PCTACH_PRESC_RST 16'h0001
`define PCTACH_CEIL_RST 24'h00_2710
`define PCTACH_FS_RST 16'h270F
`define PCTACH_RPM_MAX 16'h270F
`define PCTACH_RPM_SCALE 16'h003C

`endif

// File: design/pctach_edge_prescale.v
// Edge qualification and prescaler for the pulse input
module pctach_edge_prescale #(
    parameter PW = 16
) (
    // Clock and reset
    input wire sys_clk,
    input wire reset_n,
    // Configuration
    input wire falling_edge_select,
    input wire [PW-1:0] prescale,
    input wire clear,
    // Pulse input and strobes
    input wire pulse_in,
    output wire edge_stb,
    output reg scaled_stb
);

reg prev_r;
reg armed_r;
reg [PW-1:0] div_r;

// First sample only primes the history, so an idle-high line gives no false edge
assign edge_stb = armed_r
    & (falling_edge_select ? (prev_r & ~pulse_in) : (~prev_r & pulse_in));

always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        prev_r <= 1'b0;
        armed_r <= 1'b0;
        div_r <= {PW{1'b0}};
        scaled_stb <= 1'b0;
    end else begin
        prev_r <= pulse_in;
        armed_r <= 1'b1;
        scaled_stb <= 1'b0;
        if (clear) begin
            div_r <= {PW{1'b0}};
        end else if (edge_stb) begin
            // Every Nth qualified edge passes
            if (div_r + 1'b1 >= prescale) begin
                div_r <= {PW{1'b0}};
                scaled_stb <= 1'b1;
            end else begin
                div_r <= div_r + 1'b1;
            end
        end
    end
end

endmodule // pctach_edge_prescale

// File: design/pctach_muldiv.v
// Sequential multiply-then-divide unit, one quotient bit per cycle
module pctach_muldiv #(
    parameter AW = 24,
    parameter BW = 16,
    parameter CW = 24
) (
    // Clock and reset
    input wire sys_clk,
    input wire reset_n,
    // Operands
    input wire start,
    input wire [AW-1:0] a,
    input wire [BW-1:0] b,
    input wire [CW-1:0] c,
    // Result
    output reg busy,
    output reg done,
    output reg [AW+BW-1:0] quot
);

localparam PW = AW + BW;
localparam NW = $clog2(PW + 1);

reg [CW:0] rem_r;
reg [PW-1:0] dvd_r;
reg [PW-1:0] quo_r;
reg [NW-1:0] cnt_r;
wire [CW:0] trial;
wire take;

assign trial = {rem_r[CW-1:0], dvd_r[PW-1]};
assign take = (trial >= {1'b0, c});

always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        rem_r <= {(CW+1){1'b0}};
        dvd_r <= {PW{1'b0}};
        quo_r <= {PW{1'b0}};
        cnt_r <= {NW{1'b0}};
        busy <= 1'b0;
        done <= 1'b0;
        quot <= {PW{1'b0}};
    end else begin
        done <= 1'b0;
        if (!busy && start) begin
            dvd_r <= {{BW{1'b0}}, a} * {{AW{1'b0}}, b};
            rem_r <= {(CW+1){1'b0}};
            cnt_r <= PW[NW-1:0];
            busy <= 1'b1;
        end else if (busy) begin
            rem_r <= take ? (trial - {1'b0, c}) : trial;
            dvd_r <= {dvd_r[PW-2:0], 1'b0};
            quo_r <= {quo_r[PW-2:0], take};
            cnt_r <= cnt_r - 1'b1;
            if (cnt_r == {{(NW-1){1'b0}}, 1'b1}) begin
                busy <= 1'b0;
                done <= 1'b1;
                quot <= {quo_r[PW-2:0], take};
            end
        end
    end
end

endmodule // pctach_muldiv

// File: design/pctach_top.v
// Pulse counter and tachometer: menu, count keeping and display scaling
`include "pctach_consts.vh"

// What this block does
// - Rotation mode divides the measured pulse rate by the user divisor.
// - Rotation display uses decimal position; a reading above 9999 flags an error at any position.
// - Count-up starts at zero and increments on each prescaled pulse.
// - Count-down loads the ceiling and decrements on each prescaled pulse.
// - Grounding the external reset clears the count to its start value.
// - Count held at start while reset is low, resumes on release.
// - Count kept in nonvolatile storage and restored after power returns.
// - Source kinds: logic level, sinking with pull-up, sourcing with pull-down.
// - Rising or falling edge advances the counter as selected.
// - Only every Nth pulse reaches the counter, N the prescale factor.
// - Configurable ceiling, in prescaled pulses, defines the counting range.
// - Count equal to ceiling shows the full-scale display value.
// - Limit off lets the count pass the ceiling up to absolute maximum.
// - Error mode flags count above ceiling or below zero.
// - Clamp mode shows ceiling value when exceeded, zero when below.
// - In counter modes the first button steps source, edge, prescale, ceiling, dp, full-scale, limit, output.
// - Second and third buttons change a setting; first confirms and returns.
module pctach_top #(
    parameter CW = 24,
    parameter PW = 16,
    parameter DW = 16,
    parameter GATE_CYCLES = `PCTACH_GATE_CYCLES,
    parameter [CW-1:0] COUNT_MAX = {CW{1'b1}}
) (
    // Clock and reset
    input wire sys_clk,
    input wire reset_n,
    // Mode and pulse input
    input wire [1:0] meter_mode,
    input wire pulse_in,
    input wire ext_reset_n,
    // Buttons, debounced levels
    input wire btn_next,
    input wire btn_up,
    input wire btn_down,
    // Nonvolatile count storage
    input wire [CW-1:0] nv_count_in,
    output reg [CW-1:0] nv_count_out,
    output reg nv_write_stb,
    // Input stage control
    output wire pull_up_en,
    output wire pull_down_en,
    // Display
    output reg [DW-1:0] display_value,
    output reg [1:0] decimal_position,
    output reg display_error,
    output reg [7:0] menu_item,
    output reg menu_editing,
    output reg [CW-1:0] menu_value
);

// ----------------------------------------------------------------
// Menu states and items
// ----------------------------------------------------------------
localparam ST_RUN = 3'b001;
localparam ST_LABEL = 3'b010;
localparam ST_EDIT = 3'b100;
localparam IT_SRC = 8'b0000_0001;
localparam IT_EDGE = 8'b0000_0010;
localparam IT_PRESC = 8'b0000_0100;
localparam IT_CEIL = 8'b0000_1000;
localparam IT_DP = 8'b0001_0000;
localparam IT_FS = 8'b0010_0000;
localparam IT_LIM = 8'b0100_0000;
localparam IT_OUT = 8'b1000_0000;
localparam GW = $clog2(GATE_CYCLES + 1);

reg [2:0] st_r, btn_prev_r;
reg [7:0] item_r;
reg [CW-1:0] edit_r, ceil_r, count_r, freq_acc_r, freq_r;
reg [1:0] src_r, dp_r, lim_r;
reg fall_r, under_r, nv_loaded_r;
reg [PW-1:0] presc_r;
reg [DW-1:0] fs_r;
reg [GW-1:0] gate_r;
wire rot_mode, down_mode, edge_stb, scaled_stb, md_busy, md_done, over_ceil;
wire [2:0] btn_now, btn_stb;
wire [CW-1:0] start_val, shown_count, md_a, md_c;
wire [CW+DW-1:0] md_quot;
wire [DW-1:0] md_b;

// ----------------------------------------------------------------
// Helper functions
// ----------------------------------------------------------------
function [DW-1:0] pow10;
    input [1:0] dp;
    case (dp)
        2'h0: pow10 = 16'h0001;
        2'h1: pow10 = 16'h000A;
        2'h2: pow10 = 16'h0064;
        default: pow10 = 16'h03E8;
    endcase
endfunction
// Wrapping step of an edited setting within its bounds
function [CW-1:0] step;
    input [CW-1:0] val;
    input [CW-1:0] lo;
    input [CW-1:0] hi;
    input up;
    step = up ? ((val >= hi) ? lo : val + 1'b1) : ((val <= lo) ? hi : val - 1'b1);
endfunction
function [CW-1:0] item_max;
    input [7:0] it;
    case (it)
        IT_SRC: item_max = `PCTACH_SRC_MAX;
        IT_EDGE: item_max = `PCTACH_EDGE_MAX;
        IT_PRESC: item_max = `PCTACH_PRESC_MAX;
        IT_CEIL: item_max = COUNT_MAX;
        IT_DP: item_max = `PCTACH_DP_MAX;
        IT_FS: item_max = `PCTACH_FS_MAX;
        IT_LIM: item_max = `PCTACH_LIM_MAX;
        default: item_max = `PCTACH_SET_MIN0;
    endcase
endfunction
// Divisor, prescale and ceiling never reach zero
function [CW-1:0] item_min;
    input [7:0] it;
    item_min = (it == IT_PRESC || it == IT_CEIL) ? `PCTACH_SET_MIN1 : `PCTACH_SET_MIN0;
endfunction
// Rotation menu skips the counter-only items
function [7:0] item_next;
    input [7:0] it;
    input rot;
    case (it)
        IT_SRC: item_next = rot ? IT_PRESC : IT_EDGE;
        IT_EDGE: item_next = IT_PRESC;
        IT_PRESC: item_next = rot ? IT_DP : IT_CEIL;
        IT_CEIL: item_next = IT_DP;
        IT_DP: item_next = rot ? IT_OUT : IT_FS;
        IT_FS: item_next = IT_LIM;
        IT_LIM: item_next = IT_OUT;
        default: item_next = IT_OUT;
    endcase
endfunction
function [CW-1:0] item_get;
    input [7:0] it;
    case (it)
        IT_SRC: item_get = {{(CW-2){1'b0}}, src_r};
        IT_EDGE: item_get = {{(CW-1){1'b0}}, fall_r};
        IT_PRESC: item_get = {{(CW-PW){1'b0}}, presc_r};
        IT_CEIL: item_get = ceil_r;
        IT_DP: item_get = {{(CW-2){1'b0}}, dp_r};
        IT_FS: item_get = {{(CW-DW){1'b0}}, fs_r};
        IT_LIM: item_get = {{(CW-2){1'b0}}, lim_r};
        default: item_get = `PCTACH_SET_MIN0;
    endcase
endfunction

// ----------------------------------------------------------------
// Decodes
// ----------------------------------------------------------------
assign rot_mode = (meter_mode == `PCTACH_MODE_ROTATION);
assign down_mode = (meter_mode == `PCTACH_MODE_COUNT_DOWN);
assign btn_now = {btn_down, btn_up, btn_next};
assign btn_stb = btn_now & ~btn_prev_r;
assign start_val = down_mode ? ceil_r : {CW{1'b0}};
assign pull_up_en = (src_r == `PCTACH_SRC_SINKING);
assign pull_down_en = (src_r == `PCTACH_SRC_SOURCING);
assign over_ceil = (count_r > ceil_r);

// ----------------------------------------------------------------
// Menu
// ----------------------------------------------------------------
always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        st_r <= ST_RUN;
        item_r <= IT_SRC;
        edit_r <= {CW{1'b0}};
        btn_prev_r <= 3'h0;
        src_r <= `PCTACH_SRC_LOGIC;
        fall_r <= 1'b0;
        presc_r <= `PCTACH_PRESC_RST;
        ceil_r <= `PCTACH_CEIL_RST;
        dp_r <= 2'h0;
        fs_r <= `PCTACH_FS_RST;
        lim_r <= `PCTACH_LIM_OFF;
    end else begin
        btn_prev_r <= btn_now;
        case (st_r)
            ST_RUN: begin
                if (btn_stb[0]) begin
                    st_r <= ST_LABEL;
                    item_r <= IT_SRC;
                end
            end
            ST_LABEL: begin
                if (btn_stb[0]) begin
                    if (item_r == IT_OUT) begin
                        // Output setup lives outside this block
                        st_r <= ST_RUN;
                    end else begin
                        item_r <= item_next(item_r, rot_mode);
                    end
                end else if ((btn_stb[1] || btn_stb[2]) && item_r != IT_OUT) begin
                    st_r <= ST_EDIT;
                    edit_r <= step(item_get(item_r), item_min(item_r),
                                   item_max(item_r), btn_stb[1]);
                end
            end
            ST_EDIT: begin
                if (btn_stb[0]) begin
                    st_r <= ST_LABEL;
                    case (item_r)
                        IT_SRC: src_r <= edit_r[1:0];
                        IT_EDGE: fall_r <= edit_r[0];
                        IT_PRESC: presc_r <= edit_r[PW-1:0];
                        IT_CEIL: ceil_r <= edit_r;
                        IT_DP: dp_r <= edit_r[1:0];
                        IT_FS: fs_r <= edit_r[DW-1:0];
                        IT_LIM: lim_r <= edit_r[1:0];
                        default: st_r <= ST_LABEL;
                    endcase
                end else if (btn_stb[1] || btn_stb[2]) begin
                    edit_r <= step(edit_r, item_min(item_r), item_max(item_r), btn_stb[1]);
                end
            end
            default: st_r <= ST_RUN;
        endcase
    end
end

// ----------------------------------------------------------------
// Counter with nonvolatile restore
// ----------------------------------------------------------------
pctach_edge_prescale #(.PW(PW)) u_edge (
    .sys_clk(sys_clk), .reset_n(reset_n), .falling_edge_select(fall_r & ~rot_mode),
    .prescale(presc_r), .clear(~ext_reset_n), .pulse_in(pulse_in), .edge_stb(edge_stb),
    .scaled_stb(scaled_stb)
);

// The stored count is taken once, on the first edge after release
always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        count_r <= {CW{1'b0}};
        under_r <= 1'b0;
        nv_loaded_r <= 1'b0;
        nv_count_out <= {CW{1'b0}};
        nv_write_stb <= 1'b0;
    end else begin
        nv_write_stb <= 1'b0;
        if (!nv_loaded_r) begin
            nv_loaded_r <= 1'b1;
            count_r <= nv_count_in;
        end else if (!ext_reset_n) begin
            count_r <= start_val;
            under_r <= 1'b0;
            nv_count_out <= start_val;
            nv_write_stb <= (count_r != start_val) | under_r;
        end else if (scaled_stb && !rot_mode) begin
            // Store only on a real change, so a stuck count costs no storage wear
            if (!down_mode) begin
                // Clamp mode stops at the ceiling, otherwise the absolute maximum
                if (count_r < COUNT_MAX && !(lim_r == `PCTACH_LIM_CLAMP && count_r >= ceil_r)) begin
                    count_r <= count_r + 1'b1;
                    nv_count_out <= count_r + 1'b1;
                    nv_write_stb <= 1'b1;
                end
            end else if (count_r != {CW{1'b0}}) begin
                count_r <= count_r - 1'b1;
                nv_count_out <= count_r - 1'b1;
                nv_write_stb <= 1'b1;
            end else begin
                under_r <= 1'b1;
            end
        end
    end
end

// ----------------------------------------------------------------
// Rotation pulse frequency over a fixed gate
// ----------------------------------------------------------------
always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        gate_r <= {GW{1'b0}};
        freq_acc_r <= {CW{1'b0}};
        freq_r <= {CW{1'b0}};
    end else if (gate_r == GATE_CYCLES[GW-1:0] - 1'b1) begin
        gate_r <= {GW{1'b0}};
        freq_r <= freq_acc_r + {{(CW-1){1'b0}}, edge_stb};
        freq_acc_r <= {CW{1'b0}};
    end else begin
        gate_r <= gate_r + 1'b1;
        if (edge_stb && freq_acc_r != COUNT_MAX) begin
            freq_acc_r <= freq_acc_r + 1'b1;
        end
    end
end

// ----------------------------------------------------------------
// Display scaling
// ----------------------------------------------------------------
assign shown_count = (lim_r == `PCTACH_LIM_CLAMP && over_ceil) ? ceil_r : count_r;
assign md_a = rot_mode ? freq_r : shown_count;
assign md_b = rot_mode ? `PCTACH_RPM_SCALE * pow10(dp_r) : fs_r;
assign md_c = rot_mode ? {{(CW-PW){1'b0}}, presc_r} : ceil_r;

// Free-running: a fresh result every few dozen cycles
pctach_muldiv #(.AW(CW), .BW(DW), .CW(CW)) u_muldiv (
    .sys_clk(sys_clk), .reset_n(reset_n), .start(~md_busy), .a(md_a), .b(md_b), .c(md_c),
    .busy(md_busy), .done(md_done), .quot(md_quot)
);

always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        display_value <= {DW{1'b0}};
        decimal_position <= 2'h0;
        display_error <= 1'b0;
        menu_item <= 8'h00;
        menu_editing <= 1'b0;
        menu_value <= {CW{1'b0}};
    end else begin
        decimal_position <= dp_r;
        menu_item <= (st_r == ST_RUN) ? 8'h00 : item_r;
        menu_editing <= (st_r == ST_EDIT);
        menu_value <= (st_r == ST_EDIT) ? edit_r : item_get(item_r);
        if (md_done) begin
            display_error <= rot_mode ? (md_quot > {{CW{1'b0}}, `PCTACH_RPM_MAX})
                : ((lim_r == `PCTACH_LIM_ERROR) && (over_ceil || under_r));
            display_value <= (md_quot > {{CW{1'b0}}, {DW{1'b1}}}) ? {DW{1'b1}}
                : md_quot[DW-1:0];
        end
    end
end

endmodule // pctach_top

// File: verif/pctach_pulse_src.sv
// Pulse transmitter model driving the meter's pulse input
module pctach_pulse_src (
    // Clock
    input wire sys_clk,
    // Free-run control
    input wire run_en,
    input wire [7:0] half,
    // Pulse line
    output logic pulse_line
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;
    initial begin
        pulse_line = 1'b0;
        cnt = 0;
    end
    // Square wave; each edge is a single clean step, never bounced
    always @(posedge sys_clk) begin
        if (run_en) begin
            cnt = cnt + 1;
            if (cnt >= half) begin
                cnt = 0;
                #2 pulse_line = !pulse_line;
            end
        end
    end
    // Burst of n pulses; h cycles per level keeps edges well apart
    task automatic pulses(input int n, input int h);
        repeat (n) begin
            repeat (h) @(posedge sys_clk);
            #2 pulse_line = 1'b1;
            repeat (h) @(posedge sys_clk);
            #2 pulse_line = 1'b0;
        end
    endtask
    task automatic level(input logic v);
        @(posedge sys_clk);
        #2 pulse_line = v;
    endtask
endmodule // pctach_pulse_src

// File: verif/pctach_top_monitor.sv
// Port-level assertion checker for the pulse counter and tachometer
module pctach_top_monitor #(
    parameter CW = 24,
    parameter DW = 16
) (
    // Clock and reset
    input wire sys_clk,
    input wire reset_n,
    // Inputs
    input wire [1:0] meter_mode,
    input wire pulse_in,
    input wire ext_reset_n,
    input wire btn_next,
    input wire btn_up,
    input wire btn_down,
    input wire [CW-1:0] nv_count_in,
    // Outputs
    input wire [CW-1:0] nv_count_out,
    input wire nv_write_stb,
    input wire pull_up_en,
    input wire pull_down_en,
    input wire [DW-1:0] display_value,
    input wire [1:0] decimal_position,
    input wire display_error,
    input wire [7:0] menu_item,
    input wire menu_editing,
    input wire [CW-1:0] menu_value
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    // Last stored count; only trusted once a write was seen
    logic [CW-1:0] last_r;
    logic seen_r;
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            last_r <= {CW{1'b0}};
            seen_r <= 1'b0;
        end else if (nv_write_stb) begin
            last_r <= nv_count_out;
            seen_r <= 1'b1;
        end
    end
    property p_pull_excl;
        !(pull_up_en && pull_down_en);
    endproperty
    a_pull_excl: assert property (p_pull_excl) else $error("both pulls on");
    property p_stb_once;
        nv_write_stb |=> !nv_write_stb;
    endproperty
    a_stb_once: assert property (p_stb_once) else $error("store strobe too long");
    property p_hold_zero;
        (!ext_reset_n && meter_mode == 2'h1) [*3] |-> !nv_write_stb || nv_count_out == 0;
    endproperty
    a_hold_zero: assert property (p_hold_zero) else $error("count not held at 0");
    property p_step_up;
        nv_write_stb && seen_r && meter_mode == 2'h1 && ext_reset_n && $past(ext_reset_n)
            && $past(ext_reset_n, 2) |-> nv_count_out == last_r + 1'b1;
    endproperty
    a_step_up: assert property (p_step_up) else $error("up step wrong");
    property p_step_down;
        nv_write_stb && seen_r && last_r != 0 && meter_mode == 2'h2 && ext_reset_n
            && $past(ext_reset_n) && $past(ext_reset_n, 2) |-> nv_count_out == last_r - 1'b1;
    endproperty
    a_step_down: assert property (p_step_down) else $error("down step wrong");
    property p_menu_enter;
        $rose(btn_next) && menu_item == 8'h00 |-> ##2 menu_item == 8'h01 && !menu_editing;
    endproperty
    a_menu_enter: assert property (p_menu_enter) else $error("menu entry wrong");
    property p_menu_next;
        $rose(btn_next) && !menu_editing && meter_mode != 2'h0 && menu_item != 8'h00
            && menu_item != 8'h80 |-> ##2 menu_item == ($past(menu_item, 2) << 1);
    endproperty
    a_menu_next: assert property (p_menu_next) else $error("menu order wrong");
    property p_edit_enter;
        $rose(btn_up) && !btn_next && !$past(btn_next) && !menu_editing && menu_item != 8'h00
            && menu_item != 8'h80 |-> ##2 menu_editing && menu_item == $past(menu_item, 2);
    endproperty
    a_edit_enter: assert property (p_edit_enter) else $error("edit entry wrong");
    property p_edit_exit;
        $rose(btn_next) && menu_editing |-> ##2 !menu_editing && menu_item == $past(menu_item, 2);
    endproperty
    a_edit_exit: assert property (p_edit_exit) else $error("confirm wrong");
endmodule // pctach_top_monitor

// File: verif/test_pulse_counter_tachometer.sv
// Self-checking bench for the pulse counter and tachometer
module test_pulse_counter_tachometer;
    timeunit 1ns;
    timeprecision 1ns;
    // Short gate keeps rotation runs brief
    localparam int GATE = 200;
    logic sys_clk, reset_n, ext_reset_n, run_en;
    logic [1:0] meter_mode, decimal_position;
    logic [2:0] btn;
    logic [7:0] half, menu_item;
    logic [23:0] nv_count_in, nv_count_out, menu_value;
    logic [15:0] display_value;
    logic nv_write_stb, pull_up_en, pull_down_en, display_error, menu_editing;
    wire pulse_line;
    int n_fail, compares, cyc, n_stb, s;
    pctach_top #(.GATE_CYCLES(GATE)) u_dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .meter_mode(meter_mode), .pulse_in(pulse_line), .ext_reset_n(ext_reset_n),
        .btn_next(btn[0]), .btn_up(btn[1]), .btn_down(btn[2]), .nv_count_in(nv_count_in),
        .nv_count_out(nv_count_out), .nv_write_stb(nv_write_stb), .pull_up_en(pull_up_en),
        .pull_down_en(pull_down_en), .display_value(display_value),
        .decimal_position(decimal_position), .display_error(display_error),
        .menu_item(menu_item), .menu_editing(menu_editing), .menu_value(menu_value));
    pctach_pulse_src u_src (.sys_clk(sys_clk), .run_en(run_en), .half(half),
        .pulse_line(pulse_line));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = !sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (nv_write_stb === 1'b1) n_stb++;
        if (cyc == 20000) begin
            n_fail++;
            wrap_up();
        end
    end
    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    task automatic press(input int b);
        btn[b] = 1'b1;
        tick(1);
        btn[b] = 1'b0;
        tick(3);
    endtask
    // Open item idx, step it ups times, confirm, walk on back to run
    task automatic cfg(input int idx, input int ups);
        repeat (idx + 1) press(0);
        repeat (ups) press(1);
        press(0);
        repeat (8 - idx) press(0);
    endtask
    task automatic boot(input logic [23:0] nv, input logic [1:0] mode);
        reset_n = 1'b0;
        nv_count_in = nv;
        meter_mode = mode;
        tick(10);
        reset_n = 1'b1;
        tick(100);
    endtask
    task automatic pulse(input int n);
        u_src.pulses(n, 3);
        tick(4);
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_display();
        boot(24'h00_1388, 2'h1);
        chk("mid display", 24'h00_1387, display_value);
        boot(24'h00_2710, 2'h1);
        chk("full display", 24'h00_270F, display_value);
        chk("decimal", 24'h00_0000, decimal_position);
        pulse(1);
        chk("restored step", 24'h00_2711, nv_count_out);
        tick(60);
        chk("past ceiling", 24'h00_270F, display_value);
        chk("no error", 24'h00_0000, display_error);
        cfg(6, 1);
        tick(60);
        chk("error flag", 24'h00_0001, display_error);
        cfg(6, 1);
        pulse(1);
        tick(60);
        chk("clamp display", 24'h00_270F, display_value);
        chk("clamp count", 24'h00_2711, nv_count_out);
        $display("t_display done");
    endtask
    task automatic t_prescale();
        boot(24'h00_0000, 2'h1);
        cfg(2, 2);
        pulse(5);
        chk("after five", 24'h00_0001, nv_count_out);
        pulse(1);
        chk("after six", 24'h00_0002, nv_count_out);
        $display("t_prescale done");
    endtask
    task automatic t_edge();
        boot(24'h00_0007, 2'h1);
        cfg(1, 1);
        repeat (2) press(0);
        chk("edge shown", 24'h00_0001, menu_value);
        repeat (7) press(0);
        s = n_stb;
        u_src.level(1'b1);
        tick(6);
        chk("rise ignored", s, n_stb);
        u_src.level(1'b0);
        tick(6);
        chk("fall counted", s + 1, n_stb);
        chk("fall value", 24'h00_0008, nv_count_out);
        $display("t_edge done");
    endtask
    task automatic t_ext();
        boot(24'h00_0009, 2'h1);
        ext_reset_n = 1'b0;
        tick(4);
        chk("cleared", 24'h00_0000, nv_count_out);
        s = n_stb;
        pulse(3);
        chk("held", s, n_stb);
        ext_reset_n = 1'b1;
        tick(4);
        pulse(1);
        chk("resumed", 24'h00_0001, nv_count_out);
        boot(24'h00_0005, 2'h2);
        ext_reset_n = 1'b0;
        tick(4);
        chk("down start", 24'h00_2710, nv_count_out);
        ext_reset_n = 1'b1;
        tick(4);
        pulse(2);
        chk("down steps", 24'h00_270E, nv_count_out);
        $display("t_ext done");
    endtask
    task automatic t_source();
        boot(24'h00_0000, 2'h1);
        for (int i = 1; i <= 3; i++) begin
            cfg(0, 1);
            chk("pulls", (i == 1) ? 2'b10 : (i == 2) ? 2'b01 : 2'b00,
                {pull_up_en, pull_down_en});
        end
        $display("t_source done");
    endtask
    task automatic t_rpm();
        boot(24'h00_0000, 2'h0);
        half = 8'h05;
        run_en = 1'b1;
        tick(600);
        chk("speed", 24'h00_04B0, display_value);
        run_en = 1'b0;
        $display("t_rpm done");
    endtask
    task automatic wrap_up();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        reset_n = 1'b0;
        ext_reset_n = 1'b1;
        run_en = 1'b0;
        half = 8'h05;
        btn = 3'h0;
        meter_mode = 2'h1;
        nv_count_in = 24'h00_0000;
        tick(1);
        t_display();
        t_prescale();
        t_edge();
        t_ext();
        t_source();
        t_rpm();
        wrap_up();
    end
endmodule // test_pulse_counter_tachometer

bind pctach_top pctach_top_monitor #(.CW(CW), .DW(DW)) u_mon (.sys_clk(sys_clk),
    .reset_n(reset_n), .meter_mode(meter_mode), .pulse_in(pulse_in),
    .ext_reset_n(ext_reset_n), .btn_next(btn_next), .btn_up(btn_up), .btn_down(btn_down),
    .nv_count_in(nv_count_in), .nv_count_out(nv_count_out), .nv_write_stb(nv_write_stb),
    .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .display_value(display_value),
    .decimal_position(decimal_position), .display_error(display_error),
    .menu_item(menu_item), .menu_editing(menu_editing), .menu_value(menu_value));
